// file: design/la_defines.svh
// register offsets, field positions and command bits of the on-chip logic analyzer
// assumes a 32-bit classic wishbone slave port with a 12-bit byte address
`ifndef LA_DEFINES_SVH
`define LA_DEFINES_SVH
// ********************************************
// register map (byte addresses)
// ********************************************
`define OFS_CTRL     12'h000
`define OFS_STATUS   12'h004
`define OFS_COUNT    12'h008
`define OFS_DIV      12'h00C
`define OFS_PAGE     12'h010
`define OFS_QUAL     12'h014
`define OFS_IRQ_STAT 12'h018
`define OFS_IRQ_CLR  12'h01C
`define OFS_IRQ_EN   12'h020
// level block: 0x100 + 0x10 * level, buffer window: 0x400 + 4 * word
`define LVL_SEL      4'h1
`define BUF_SEL      2'h1
`define SUB_PAT      2'h0
`define SUB_MASK     2'h1
`define SUB_TCTL     2'h2
// ********************************************
// fields
// ********************************************
`define CTRL_ARM     0
`define CTRL_RST     1
`define QUAL_VAL     8
`define QUAL_EN      9
`define TCTL_COND    16
`define ST_LVL_POS   4
`define ST_PTR_POS   16
`define IRQ_TRIG     0
`define IRQ_DONE     1
`endif

// file: design/analyzer_pkg.sv
// types shared by the logic analyzer design
// assumes nothing of its surroundings
package analyzer_pkg;
  // analyzer capture state as shown in the status register
  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_ARMED     = 2'b01,
    ST_TRIGGERED = 2'b10
  } la_state_type;
endpackage

// file: design/onchip_logic_analyzer.sv
// on-chip logic analyzer: trigger levels, divider, qualifier, paged trace buffer
// assumes probe_i comes from logic on clk_i and a classic wishbone master
`timescale 1ns/10ps
`include "la_defines.svh"
module onchip_logic_analyzer #(
  parameter int WIDTH  = 32,  // probed vector width, at most 32
  parameter int DEPTH  = 64,  // trace buffer depth, power of two
  parameter int LEVELS = 2,   // trigger levels, at least 2
  parameter int PAGE   = 16,  // buffer words per page, power of two
  parameter int DW     = 16   // divider width
) (
  input  wire logic             clk_i,   // sample and bus clock
  input  wire logic             rst_i,   // synchronous reset, high
  input  wire logic             cyc_i,   // wishbone cycle
  input  wire logic             stb_i,   // wishbone strobe
  input  wire logic             we_i,    // wishbone write
  input  wire logic [11:0]      adr_i,   // byte address
  input  wire logic [3:0]       sel_i,   // byte lanes
  input  wire logic [31:0]      dat_i,   // write data
  output logic      [31:0]      dat_o,   // read data
  output logic                  ack_o,   // wishbone acknowledge
  input  wire logic [WIDTH-1:0] probe_i, // probed signals
  output logic                  irq_o    // level interrupt
);
  localparam int AW  = $clog2(DEPTH);
  localparam int LW  = $clog2(LEVELS);
  localparam int QW  = $clog2(WIDTH);
  localparam int PWB = $clog2(PAGE);
  localparam int PGW = AW - PWB;

  // ********************************************
  // state
  // ********************************************
  typedef struct packed {
    analyzer_pkg::la_state_type      st;
    logic [DEPTH-1:0][WIDTH-1:0]     mem;
    logic [AW-1:0]                   wptr;
    logic [AW-1:0]                   post;
    logic [AW-1:0]                   count;
    logic [DW-1:0]                   div;
    logic [DW-1:0]                   divcnt;
    logic [PGW-1:0]                  page;
    logic [QW-1:0]                   qbit;
    logic                            qval;
    logic                            qen;
    logic [LEVELS-1:0][WIDTH-1:0]    pat;
    logic [LEVELS-1:0][WIDTH-1:0]    msk;
    logic [LEVELS-1:0][15:0]         tcnt;
    logic [LEVELS-1:0]               cond;
    logic [15:0]                     hits;
    logic [LW-1:0]                   lvl;
    logic [1:0]                      irq_st;
    logic [1:0]                      irq_en;
    logic                            ack;
    logic [31:0]                     dat;
  } state_type;

  state_type        r;
  state_type        n;
  logic             req;
  logic             wr;
  logic             tick;
  logic             store;
  logic             met;
  logic             fire;
  logic             arm;
  logic             stop;
  logic [31:0]      rd;
  logic [31:0]      wm;
  logic [LW-1:0]    wl;
  logic [AW-1:0]    bidx;

  // byte-lane merge of write data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // ********************************************
  // next state
  // ********************************************
  always_comb begin
    n     = r;
    req   = cyc_i & stb_i;
    wr    = req & we_i & r.ack;
    tick  = 1'b0;
    store = 1'b0;
    met   = 1'b0;
    fire  = 1'b0;
    wl    = adr_i[4+LW-1:4];
    bidx  = {r.page, adr_i[PWB+1:2]};
    wm    = 32'h0000_0000;
    rd    = 32'h0000_0000;
    // read mux, registered into dat when the request is first seen
    case (adr_i)
      `OFS_STATUS: rd = 32'(r.st) | (32'(r.lvl) << `ST_LVL_POS) | (32'(r.wptr) << `ST_PTR_POS);
      `OFS_COUNT:    rd = 32'(r.count);
      `OFS_DIV:      rd = 32'(r.div);
      `OFS_PAGE:     rd = 32'(r.page);
      `OFS_QUAL:     rd = 32'(r.qbit) | (32'(r.qval) << `QUAL_VAL) | (32'(r.qen) << `QUAL_EN);
      `OFS_IRQ_STAT: rd = 32'(r.irq_st);
      `OFS_IRQ_EN:   rd = 32'(r.irq_en);
      default: begin
        if (adr_i[11:8] == `LVL_SEL && adr_i[7:4] < 4'(LEVELS)) begin
          case (adr_i[3:2])
            `SUB_PAT:  rd = 32'(r.pat[wl]);
            `SUB_MASK: rd = 32'(r.msk[wl]);
            `SUB_TCTL: rd = 32'(r.tcnt[wl]) | (32'(r.cond[wl]) << `TCTL_COND);
            default:   rd = 32'h0000_0000;
          endcase
        end else if (adr_i[11:10] == `BUF_SEL && adr_i[9:PWB+2] == '0) begin
          rd = 32'(r.mem[bidx]);
        end
      end
    endcase
    // one-cycle answer; the write lands on the edge where the master sees ack
    // a held strobe in the ack cycle is not taken as a second request
    n.ack = req & ~r.ack;
    if (req & ~r.ack) begin
      n.dat = rd;
    end
    arm  = wr && adr_i == `OFS_CTRL && sel_i[0] && dat_i[`CTRL_ARM];
    stop = wr && adr_i == `OFS_CTRL && sel_i[0] && dat_i[`CTRL_RST];
    // register writes
    if (wr) begin
      case (adr_i)
        `OFS_COUNT: begin
          wm = merge(32'(r.count), dat_i, sel_i);
          n.count = wm[AW-1:0];
        end
        `OFS_DIV: begin
          wm = merge(32'(r.div), dat_i, sel_i);
          n.div = wm[DW-1:0];
        end
        `OFS_PAGE: begin
          wm = merge(32'(r.page), dat_i, sel_i);
          n.page = wm[PGW-1:0];
        end
        `OFS_QUAL: begin
          wm = merge(32'(r.qbit) | (32'(r.qval) << `QUAL_VAL) | (32'(r.qen) << `QUAL_EN),
                     dat_i, sel_i);
          n.qbit = wm[QW-1:0];
          n.qval = wm[`QUAL_VAL];
          n.qen  = wm[`QUAL_EN];
        end
        // write one to clear; a flag set in the same cycle wins as the set comes later
        `OFS_IRQ_CLR: n.irq_st = r.irq_st & ~dat_i[1:0];
        `OFS_IRQ_EN: begin
          wm = merge(32'(r.irq_en), dat_i, sel_i);
          n.irq_en = wm[1:0];
        end
        default: begin
          if (adr_i[11:8] == `LVL_SEL && adr_i[7:4] < 4'(LEVELS)) begin
            case (adr_i[3:2])
              `SUB_PAT: begin
                wm = merge(32'(r.pat[wl]), dat_i, sel_i);
                n.pat[wl] = wm[WIDTH-1:0];
              end
              `SUB_MASK: begin
                wm = merge(32'(r.msk[wl]), dat_i, sel_i);
                n.msk[wl] = wm[WIDTH-1:0];
              end
              `SUB_TCTL: begin
                wm = merge(32'(r.tcnt[wl]) | (32'(r.cond[wl]) << `TCTL_COND), dat_i, sel_i);
                n.tcnt[wl] = wm[15:0];
                n.cond[wl] = wm[`TCTL_COND];
              end
              default: n.tcnt = r.tcnt;
            endcase
          end
        end
      endcase
    end
    // sampling: divider, qualifier, circular store
    // the first sample lands div cycles after the arm write, then one every div cycles
    if (r.st != analyzer_pkg::ST_IDLE) begin
      tick = ({1'b0, r.divcnt} + (DW+1)'(1)) >= {1'b0, r.div};
      n.divcnt = tick ? '0 : r.divcnt + 1'b1;
      store = tick & (~r.qen | (probe_i[r.qbit] == r.qval));
      if (store) begin
        n.mem[r.wptr] = probe_i;
        n.wptr = r.wptr + 1'b1;
      end
    end
    // trigger levels in order, masked compare against the condition
    // only stored samples advance the levels, so the qualifier gates the trigger too
    met = ((((probe_i ^ r.pat[r.lvl]) & r.msk[r.lvl]) == '0) == r.cond[r.lvl]);
    case (r.st)
      analyzer_pkg::ST_ARMED: begin
        if (store && met) begin
          if (({1'b0, r.hits} + 17'h0_0001) >= {1'b0, r.tcnt[r.lvl]}) begin
            n.hits = '0;
            if (r.lvl == LW'(LEVELS - 1)) begin
              fire = 1'b1;
            end else begin
              n.lvl = r.lvl + 1'b1;
            end
          end else begin
            n.hits = r.hits + 1'b1;
          end
        end
        if (fire) begin
          n.irq_st[`IRQ_TRIG] = 1'b1;
          n.post = '0;
          if (r.count == '0) begin
            n.st = analyzer_pkg::ST_IDLE;
            n.irq_st[`IRQ_DONE] = 1'b1;
          end else begin
            n.st = analyzer_pkg::ST_TRIGGERED;
          end
        end
      end
      analyzer_pkg::ST_TRIGGERED: begin
        if (store) begin
          n.post = r.post + 1'b1;
          if (n.post == r.count) begin
            n.st = analyzer_pkg::ST_IDLE;
            n.irq_st[`IRQ_DONE] = 1'b1;
          end
        end
      end
      default: n.st = r.st;
    endcase
    // software commands; reset beats arm
    // arm clears pointer, level and match count but keeps the old buffer contents
    if (arm) begin
      n.st     = analyzer_pkg::ST_ARMED;
      n.lvl    = '0;
      n.hits   = '0;
      n.divcnt = '0;
      n.wptr   = '0;
      n.post   = '0;
    end
    if (stop) begin
      n.st = analyzer_pkg::ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign dat_o = r.dat;
  assign ack_o = r.ack;
  assign irq_o = |(r.irq_st & r.irq_en);

  // ********************************************
  // checks
  // ********************************************
  // every check runs on the one sample clock and sleeps through reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ARM_STARTS: assert property (arm && !stop |=> r.st == analyzer_pkg::ST_ARMED)
    else $error("arm did not start capture");
  AST_POST_BOUND: assert property (r.st == analyzer_pkg::ST_TRIGGERED |-> r.post < r.count)
    else $error("post-trigger count overrun");
  AST_DIV_SPACING: assert property (tick && $past(tick) |-> r.div <= DW'(1))
    else $error("samples closer than the divider allows");
  AST_MASK_WRITE: assert property (wr && adr_i == {`LVL_SEL, 4'h0, `SUB_MASK, 2'b00} && sel_i == 4'hF
                                   |=> r.msk[0] == $past(dat_i[WIDTH-1:0]))
    else $error("mask write not stored");
  AST_QUAL_GATE: assert property (r.qen && store |-> probe_i[r.qbit] == r.qval)
    else $error("unqualified sample stored");
  AST_STOP_IDLE: assert property (stop |=> r.st == analyzer_pkg::ST_IDLE ##1
                                  r.st == analyzer_pkg::ST_IDLE || $past(arm))
    else $error("reset command did not stop capture");
  AST_STATUS_READ: assert property (req && !r.ack && adr_i == `OFS_STATUS
                                    |=> ack_o && dat_o[1:0] == $past(r.st))
    else $error("status read wrong");
  AST_TRIG_LAST: assert property (r.st == analyzer_pkg::ST_ARMED && !stop && !arm &&
                                  n.st != analyzer_pkg::ST_ARMED
                                  |-> r.lvl == LW'(LEVELS - 1) && met && store)
    else $error("trigger fired before last level");
  AST_WRAP: assert property (store && !arm && r.wptr == AW'(DEPTH - 1) |=> r.wptr == '0)
    else $error("buffer pointer did not wrap");

  // ********************************************
  // checks on the bus answer, the idle buffer, level stepping, the trigger flag and the end of capture
  // ********************************************
  // the answer is one cycle wide, so the master never sees a stale acknowledge
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  // nothing is written to the buffer while idle unless an arm lands
  AST_IDLE_QUIET: assert property (r.st == analyzer_pkg::ST_IDLE && !arm
                                   |=> $stable(r.wptr))
    else $error("buffer written while idle");
  // the last post-trigger sample ends capture and raises the done flag
  AST_POST_DONE: assert property (r.st == analyzer_pkg::ST_TRIGGERED && store &&
                                  !arm && !stop && r.post + 1'b1 == r.count
                                  |=> r.st == analyzer_pkg::ST_IDLE &&
                                  r.irq_st[`IRQ_DONE])
    else $error("capture did not end after the post-trigger count");
  // levels only step forward by one; only an arm sends them back to the first
  AST_LEVEL_STEP: assert property (!arm |=> r.lvl == $past(r.lvl) ||
                                   r.lvl == $past(r.lvl) + 1'b1)
    else $error("trigger level skipped");
  // the trigger always leaves its sticky flag behind, even against a clear
  AST_TRIG_FLAG: assert property (fire |=> r.irq_st[`IRQ_TRIG])
    else $error("trigger flag not set");
endmodule // onchip_logic_analyzer

// file: dv/probe_source.sv
// probed signal source: a free-running count, one step per clock
// assumes the analyzer samples it on the same clock edge
`timescale 1ns/10ps
module probe_source (
  input  wire logic        clk_i,  // sample clock
  input  wire logic        rst_i,  // synchronous reset, high
  output logic      [31:0] probe_o // probed vector
);
  // a counting pattern makes every sample distinct and predictable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      probe_o <= 32'h0000_0000;
    end else begin
      probe_o <= probe_o + 32'h0000_0001;
    end
  end
endmodule // probe_source

// file: dv/onchip_logic_analyzer_test.sv
// self-checking bench for the logic analyzer over classic wishbone
// assumes probe_source drives a counting probe vector
`timescale 1ns/10ps
module onchip_logic_analyzer_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o, probe, r;
  logic        ack_o, irq_o;
  int          error_cnt = 0;
  int          cmp_count = 0;
  // ********************************************
  // clock, partner and design
  // ********************************************
  always #25 clk_i = ~clk_i;
  probe_source u_src (.clk_i(clk_i), .rst_i(rst_i), .probe_o(probe));
  onchip_logic_analyzer u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .probe_i(probe), .irq_o(irq_o));
  // ********************************************
  // shared tasks
  // ********************************************
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one classic cycle, held until ack, read data kept in r
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(n, r, e);
  endtask
  task automatic st(input logic [1:0] e);
    wb(1'b0, 12'h004, 32'h0000_0000, 4'hF);
    chk("state", {30'h0, r[1:0]}, {30'h0, e});
  endtask
  task automatic irq(input logic e);
    @(negedge clk_i);
    chk("irq", {31'h0, irq_o}, {31'h0, e});
  endtask
  // level 0 from arguments, level 1 always matches, then arm
  task automatic cfg(input logic [31:0] dv, q, p, m, c, n);
    wr(12'h00C, dv);
    wr(12'h014, q);
    wr(12'h100, p);
    wr(12'h104, m);
    wr(12'h108, c);
    wr(12'h114, 32'h0000_0000);
    wr(12'h118, 32'h0001_0001);
    wr(12'h008, n);
    wr(12'h01C, 32'h0000_0003);
    wr(12'h000, 32'h0000_0001);
  endtask
  // sample k places before the write pointer, through the page window
  task automatic tail(input logic [5:0] k);
    logic [5:0] i;
    wb(1'b0, 12'h004, 32'h0000_0000, 4'hF);
    i = r[21:16] - k;
    wr(12'h010, {30'h0, i[5:4]});
    wb(1'b0, {6'h10, i[3:0], 2'b00}, 32'h0000_0000, 4'hF);
  endtask
  task automatic wait_done;
    do wb(1'b0, 12'h018, 32'h0000_0000, 4'hF); while (r[1] !== 1'b1);
  endtask
  // ********************************************
  // scenarios
  // ********************************************
  task automatic s_reset;
    st(2'h0);
    rdc("div", 12'h00C, 32'h0000_0000);
    rdc("unmapped", 12'h440, 32'h0000_0000);
    irq(1'b0);
  endtask
  task automatic s_regs;
    wr(12'h110, 32'hA5A5_5A5A);
    rdc("pattern", 12'h110, 32'hA5A5_5A5A);
    wr(12'h114, 32'hFFFF_FFFF);
    wb(1'b1, 12'h114, 32'h0000_0000, 4'h2);
    rdc("mask", 12'h114, 32'hFFFF_00FF);
  endtask
  task automatic s_match;
    cfg(32'h1, 32'h0, 32'h0000_0400, 32'hFFFF_FFF0, 32'h0001_0003, 32'h3);
    st(2'h1);
    wait_done;
    st(2'h0);
    tail(6'd1);
    chk("last", r, 32'h0000_0406);
    tail(6'd5);
    chk("match", r, 32'h0000_0402);
    tail(6'd0);
    chk("oldest", r, 32'h0000_03C7);
  endtask
  task automatic s_div;
    logic [31:0] a;
    cfg(32'h4, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0000_0001, 32'h3F);
    wr(12'h020, 32'h0000_0001);
    do @(negedge clk_i); while (irq_o !== 1'b1);
    st(2'h2);
    wr(12'h020, 32'h0000_0002);
    irq(1'b0);
    wait_done;
    irq(1'b1);
    wr(12'h01C, 32'h0000_0003);
    rdc("irq_status", 12'h018, 32'h0000_0000);
    irq(1'b0);
    tail(6'd1);
    a = r;
    tail(6'd2);
    chk("step", a - r, 32'h0000_0004);
    tail(6'd0);
    chk("span", a - r, 32'h0000_00FC);
  endtask
  task automatic s_qual;
    logic [31:0] a;
    cfg(32'h1, 32'h0000_0300, 32'h0, 32'h0, 32'h0001_0001, 32'h5);
    wait_done;
    tail(6'd1);
    a = r;
    tail(6'd2);
    chk("qual_step", a - r, 32'h0000_0002);
    chk("qual_bit", {31'h0, a[0]}, 32'h0000_0001);
  endtask
  task automatic s_stop;
    logic [31:0] a;
    cfg(32'h1, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0001_0001, 32'h0);
    st(2'h1);
    wr(12'h000, 32'h0000_0002);
    st(2'h0);
    a = r;
    st(2'h0);
    chk("pointer", r, a);
  endtask
  // ********************************************
  // run and verdict
  // ********************************************
  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset;
    s_regs;
    s_match;
    s_div;
    s_qual;
    s_stop;
    report_and_stop;
  end
endmodule // onchip_logic_analyzer_test
